// *** logic/owbe_defs.vh ***
`ifndef OWBE_DEFS_VH
`define OWBE_DEFS_VH
// ****************************************
// command codes
// ****************************************
`define OWBE_CMD_WRITE_BYTE 8'hA5
`define OWBE_CMD_READ_BYTE 8'h96
`define OWBE_CMD_SINGLE_BIT 8'h87
`define OWBE_BIT_VALUE_POS 7
`define OWBE_BYTE_SLOTS 4'h8
// ****************************************
// read pointer codes
// ****************************************
`define OWBE_PTR_STATUS 2'h0
`define OWBE_PTR_READ_DATA 2'h1
// ****************************************
// slot timing, cycles at 250 MHz
// ****************************************
`define OWBE_START_MAX_PS 262500
`define OWBE_CLK_PERIOD_PS 4000
`define OWBE_START_MAX_CYC (`OWBE_START_MAX_PS / `OWBE_CLK_PERIOD_PS)
`define OWBE_SLOT_STD_CYC 17500
`define OWBE_SLOT_OD_CYC 2500
`define OWBE_LOW_W0_STD_CYC 15000
`define OWBE_LOW_W0_OD_CYC 2000
`define OWBE_LOW_W1_STD_CYC 1500
`define OWBE_LOW_W1_OD_CYC 250
`define OWBE_SAMPLE_STD_CYC 3000
`define OWBE_SAMPLE_OD_CYC 500
`endif

// *** logic/owbe_engine.v ***
// Notes on behaviour
// R1 - single-bit command uses only bit seven of its parameter byte
// R2 - code A5h plus a data byte sends eight write slots
// R3 - write byte goes out lsb first, only after whole byte received
// R4 - write-byte bus activity starts within 262.5ns of last bit
// R5 - write byte finishes within eight slots plus 262.5ns
// R6 - busy flag stays one for eight slots during byte write or read
// R7 - write-byte code while busy: no acknowledge, command dropped
// R8 - read-byte code while busy: no acknowledge, command dropped
// R9 - code 96h runs eight read slots into the read data register
// R10 - read byte starts within 262.5ns and ends within eight slots more
// R11 - accepted byte command points the read pointer at status
// R12 - host selects read data register by pointer before reading; here read_pointer only ever loads status and read_data is a direct output
// R13 - write uses speed, strong and active pullup; read skips strong
// R14 - new bus command accepted only after prior activity ends
// R15 - code 87h makes write-zero or write-one slot and samples result
// R16 - first read slot lands in bit zero, eighth in bit seven
`timescale 1ns/10ps
`include "owbe_defs.vh"
module owbe_engine #(
  parameter SLOT_STD = `OWBE_SLOT_STD_CYC,
  parameter SLOT_OD = `OWBE_SLOT_OD_CYC,
  parameter LOW0_STD = `OWBE_LOW_W0_STD_CYC,
  parameter LOW0_OD = `OWBE_LOW_W0_OD_CYC,
  parameter LOW1_STD = `OWBE_LOW_W1_STD_CYC,
  parameter LOW1_OD = `OWBE_LOW_W1_OD_CYC,
  parameter SAMP_STD = `OWBE_SAMPLE_STD_CYC,
  parameter SAMP_OD = `OWBE_SAMPLE_OD_CYC
) (
  input wire clock,
  input wire reset,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire param_valid,
  input wire [7:0] param_byte,
  input wire overdrive_speed_select,
  input wire strong_pullup_enable,
  input wire active_pullup_enable,
  input wire line_in,
  output reg cmd_ack,
  output reg cmd_nack,
  output reg bus_busy_flag,
  output reg single_bit_result,
  output reg [7:0] read_data,
  output reg [1:0] read_pointer,
  output reg line_oe_n,
  output reg line_out,
  output reg strong_pullup_on,
  output reg active_pullup_on
);
  localparam CW = 16;
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SLOT = 2'h2;

  // ****************************************
  // input synchroniser for the bus line
  // ****************************************
  reg line_m_r, line_s_r;
  always @(posedge clock)
  begin
    line_m_r <= line_in;
    line_s_r <= line_m_r;
  end

  // ****************************************
  // two-entry parameter buffer; ready drops only when both entries are full
  // ****************************************
  reg [7:0] buf_data [0:1];
  reg [1:0] buf_cnt_r;
  reg buf_wp_r, buf_rp_r;
  wire buf_ready = (buf_cnt_r != 2'h2);
  wire buf_pop;
  wire buf_open;
  // a data byte is only taken while a command waits for it, so the byte of
  // a refused command feeds the next command only if it comes in the cycle after the awaited byte
  wire buf_push = param_valid && buf_ready && buf_open; // [R7]
  always @(posedge clock)
  begin
    if (reset)
    begin
      buf_cnt_r <= 2'h0;
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
    end
    else
    begin
      if (buf_push)
      begin
        buf_data[buf_wp_r] <= param_byte;
        buf_wp_r <= ~buf_wp_r;
      end
      if (buf_pop)
        buf_rp_r <= ~buf_rp_r;
      buf_cnt_r <= buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end
  wire buf_valid = (buf_cnt_r != 2'h0);
  wire [7:0] buf_head = buf_data[buf_rp_r];

  function [CW-1:0] pick;
    input od;
    input [CW-1:0] s;
    input [CW-1:0] o;
    begin
      pick = od ? o : s;
    end
  endfunction

  // ****************************************
  // command sequencer
  // ****************************************
  reg [1:0] state_r;
  reg [1:0] kind_r; // 0 write byte, 1 read byte, 2 single bit
  reg [7:0] shift_r;
  reg [3:0] left_r;
  reg [CW-1:0] cnt_r;
  reg od_r, spu_r, apu_r, bitv_r;
  wire is_wr = (cmd_code == `OWBE_CMD_WRITE_BYTE);
  wire is_rd = (cmd_code == `OWBE_CMD_READ_BYTE);
  wire is_sb = (cmd_code == `OWBE_CMD_SINGLE_BIT);
  assign buf_pop = (state_r == ST_WAIT) && buf_valid;
  assign buf_open = (state_r == ST_WAIT);
  wire [CW-1:0] slot_len = pick(od_r, SLOT_STD[CW-1:0], SLOT_OD[CW-1:0]);
  wire [CW-1:0] low_len = bitv_r ? pick(od_r, LOW1_STD[CW-1:0],
    LOW1_OD[CW-1:0]) : pick(od_r, LOW0_STD[CW-1:0], LOW0_OD[CW-1:0]);
  wire [CW-1:0] samp_at = pick(od_r, SAMP_STD[CW-1:0], SAMP_OD[CW-1:0]);

  always @(posedge clock)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      kind_r <= 2'h0;
      shift_r <= 8'h00;
      left_r <= 4'h0;
      cnt_r <= {CW{1'b0}};
      od_r <= 1'b0;
      spu_r <= 1'b0;
      apu_r <= 1'b0;
      bitv_r <= 1'b1;
      cmd_ack <= 1'b0;
      cmd_nack <= 1'b0;
      bus_busy_flag <= 1'b0;
      single_bit_result <= 1'b0;
      read_data <= 8'h00;
      read_pointer <= `OWBE_PTR_STATUS;
      line_oe_n <= 1'b1;
      line_out <= 1'b0;
      strong_pullup_on <= 1'b0;
      active_pullup_on <= 1'b0;
    end
    else
    begin
      cmd_ack <= 1'b0;
      cmd_nack <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          line_oe_n <= 1'b1;
          active_pullup_on <= 1'b0;
          if (cmd_valid && (is_wr || is_rd || is_sb))
          begin
            cmd_ack <= 1'b1; // [R14]
            read_pointer <= `OWBE_PTR_STATUS; // [R11]
            od_r <= overdrive_speed_select;
            apu_r <= active_pullup_enable;
            spu_r <= strong_pullup_enable && !is_rd; // [R13]
            bus_busy_flag <= 1'b1; // [R6]
            if (is_rd)
            begin
              kind_r <= 2'h1;
              bitv_r <= 1'b1;
              left_r <= `OWBE_BYTE_SLOTS;
              cnt_r <= {CW{1'b0}};
              state_r <= ST_SLOT; // [R9] [R10]
            end
            else
            begin
              kind_r <= is_wr ? 2'h0 : 2'h2;
              state_r <= ST_WAIT;
            end
          end
        end
        ST_WAIT:
        begin
          // byte fully received before any slot starts [R3] [R4]
          if (buf_valid)
          begin
            if (kind_r == 2'h0)
            begin
              shift_r <= buf_head; // [R2]
              bitv_r <= buf_head[0];
              left_r <= `OWBE_BYTE_SLOTS;
            end
            else
            begin
              bitv_r <= buf_head[`OWBE_BIT_VALUE_POS]; // [R1]
              left_r <= 4'h1;
            end
            cnt_r <= {CW{1'b0}};
            state_r <= ST_SLOT;
          end
        end
        ST_SLOT:
        begin
          active_pullup_on <= apu_r; // [R13]
          strong_pullup_on <= 1'b0;
          line_oe_n <= (cnt_r >= low_len);
          line_out <= 1'b0;
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == samp_at)
          begin
            shift_r <= {line_s_r, shift_r[7:1]}; // [R16]
            if (kind_r == 2'h2)
              single_bit_result <= line_s_r; // [R15]
          end
          if (cnt_r == slot_len - 1'b1)
          begin
            cnt_r <= {CW{1'b0}};
            left_r <= left_r - 4'h1;
            // the sample has already shifted the next bit into place;
            // read slots must stay write-one whatever the line returned
            bitv_r <= (kind_r == 2'h1) || shift_r[0]; // [R3] [R9]
            if (left_r == 4'h1)
            begin
              if (kind_r == 2'h1)
                read_data <= shift_r; // [R9]
              strong_pullup_on <= spu_r; // [R13]
              bus_busy_flag <= 1'b0; // [R5] [R6]
              line_oe_n <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
      // busy code: refuse, nothing else changes [R7] [R8]
      if (cmd_valid && state_r != ST_IDLE)
        cmd_nack <= 1'b1;
    end
  end
endmodule

// *** verification/owbe_engine_props.sv ***
`timescale 1ns/10ps
`include "owbe_defs.vh"
// ****************************************
// port checks of the byte engine
// ****************************************
module owbe_engine_props #(
  parameter [15:0] SLOT = 16'h0028,
  parameter [15:0] SLOT_OD = 16'h0018
) (
  input wire clock,
  input wire reset,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire param_valid,
  input wire overdrive_speed_select,
  input wire cmd_ack,
  input wire cmd_nack,
  input wire bus_busy_flag,
  input wire [1:0] read_pointer,
  input wire line_oe_n,
  input wire strong_pullup_on
);
  reg [15:0] cnt_r;
  wire [15:0] cnt_nxt;
  reg od_r;
  reg wait_r;
  wire idle_cmd = cmd_valid && !bus_busy_flag;
  wire wr_go = idle_cmd && cmd_code == `OWBE_CMD_WRITE_BYTE;
  wire rd_go = idle_cmd && cmd_code == `OWBE_CMD_READ_BYTE;
  wire sb_go = idle_cmd && cmd_code == `OWBE_CMD_SINGLE_BIT;
  wire [15:0] slot_w = od_r ? SLOT_OD : SLOT;
  // speed and the wait for a data byte are latched when a code is taken;
  // a refused data byte during a slot must not count as a write start
  always @(posedge clock)
  begin
    if (reset)
    begin
      od_r <= 1'b0;
      wait_r <= 1'b0;
    end
    else
    begin
      if (idle_cmd)
        od_r <= overdrive_speed_select;
      if (wr_go || sb_go)
        wait_r <= 1'b1;
      else if (!line_oe_n)
        wait_r <= 1'b0;
    end
  end
  // count from the first drive so the wait for the data byte is left out
  assign cnt_nxt = (cnt_r != 0 || !line_oe_n) ? cnt_r + 16'h0001 : cnt_r;
  always @(posedge clock)
    cnt_r <= (reset || !bus_busy_flag) ? 16'h0000 : cnt_nxt;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_ack; wr_go |=> cmd_ack && !cmd_nack; endproperty
  a_ack: assert property (p_ack) else $error("write code not taken");
  property p_nack; cmd_valid && bus_busy_flag |=> cmd_nack && !cmd_ack;
  endproperty
  a_nack: assert property (p_nack) else $error("busy code taken");
  property p_ptr; cmd_ack |=> read_pointer == `OWBE_PTR_STATUS; endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not on status");
  property p_wstart; wait_r && param_valid
    |-> ##[1:66] !line_oe_n; endproperty
  a_wstart: assert property (p_wstart) else $error("write start late");
  property p_rstart; rd_go |-> ##[1:67] !line_oe_n; endproperty
  a_rstart: assert property (p_rstart) else $error("read start late");
  property p_len; $fell(bus_busy_flag) |-> cnt_r inside
    {[slot_w-2:slot_w+66], [8*slot_w-2:8*slot_w+66]}; endproperty
  a_len: assert property (p_len) else $error("busy span wrong");
  property p_idle; !bus_busy_flag |-> line_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("line driven idle");
  property p_spu; rd_go |=> ##1 !strong_pullup_on [*8]; endproperty
  a_spu: assert property (p_spu) else $error("strong pullup on read");
  c_nack: cover property (cmd_nack);
  c_byte: cover property ($fell(bus_busy_flag) && cnt_r > 4 * SLOT);
  c_read: cover property (rd_go);
  c_od: cover property ($fell(bus_busy_flag) && od_r);
endmodule
bind owbe_engine owbe_engine_props #(.SLOT(SLOT_STD), .SLOT_OD(SLOT_OD))
  owbe_engine_props_i (
  .clock(clock), .reset(reset), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .param_valid(param_valid),
  .overdrive_speed_select(overdrive_speed_select), .cmd_ack(cmd_ack),
  .cmd_nack(cmd_nack), .bus_busy_flag(bus_busy_flag),
  .read_pointer(read_pointer), .line_oe_n(line_oe_n),
  .strong_pullup_on(strong_pullup_on));

// *** verification/owbe_engine_tb.sv ***
`timescale 1ns/10ps
`include "owbe_defs.vh"
`define CHK(nm, e, g) \
  begin \
    n_compared = n_compared + 1; \
    if ((g) !== (e)) \
    begin \
      n_errors = n_errors + 1; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end
module owbe_engine_tb;
  reg clock = 1'b0;
  reg reset = 1'b1;
  reg cmd_valid = 1'b0;
  reg param_valid = 1'b0;
  reg spu_en = 1'b0;
  reg apu_en = 1'b0;
  reg tx_en = 1'b0;
  reg od_en = 1'b0;
  reg [7:0] cmd_code = 8'h00;
  reg [7:0] param_byte = 8'h00;
  reg [7:0] tx_byte = 8'hC6;
  wire cmd_ack, cmd_nack, bus_busy_flag, single_bit_result, line_oe_n;
  wire line_out, strong_pullup_on, active_pullup_on, line_in;
  wire [7:0] read_data, rx_byte;
  wire [1:0] read_pointer;
  integer n_errors = 0;
  integer n_compared = 0;
  integer i, w;
  always #2 clock = ~clock;
  owbe_engine #(.SLOT_STD(40), .LOW0_STD(30), .LOW1_STD(4), .SAMP_STD(8),
    .SLOT_OD(24), .LOW0_OD(20), .LOW1_OD(2), .SAMP_OD(6))
  owbe_engine_i (.clock(clock), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .param_valid(param_valid),
    .param_byte(param_byte), .overdrive_speed_select(od_en),
    .strong_pullup_enable(spu_en), .active_pullup_enable(apu_en),
    .line_in(line_in), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack),
    .bus_busy_flag(bus_busy_flag), .single_bit_result(single_bit_result),
    .read_data(read_data), .read_pointer(read_pointer),
    .line_oe_n(line_oe_n), .line_out(line_out),
    .strong_pullup_on(strong_pullup_on),
    .active_pullup_on(active_pullup_on));
  owbe_slave_model owbe_slave_model_i (.clock(clock), .line_oe_n(line_oe_n),
    .tx_en(tx_en), .tx_byte(tx_byte), .line_in(line_in), .rx_byte(rx_byte));
  task wrap_up;
  begin
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task issue(input [7:0] code, input is_param);
  begin
    @(posedge clock);
    cmd_valid <= !is_param;
    param_valid <= is_param;
    cmd_code <= code;
    param_byte <= code;
    @(posedge clock);
    cmd_valid <= 1'b0;
    param_valid <= 1'b0;
    #1;
  end
  endtask
  task settle;
  begin
    for (w = 0; w < 2000 && bus_busy_flag !== 1'b0; w = w + 1)
      @(posedge clock);
    repeat (2) @(posedge clock);
    #1;
    `CHK("busy_end", 1'b0, bus_busy_flag)
  end
  endtask
  initial
  begin
    #20000;
    n_errors = n_errors + 1;
    wrap_up;
  end
  initial
  begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    spu_en <= 1'b1;
    apu_en <= 1'b1;
    #1;
    `CHK("oe_idle", 1'b1, line_oe_n)
    issue(`OWBE_CMD_WRITE_BYTE, 1'b0);
    `CHK("wr_ack", 1'b1, cmd_ack)
    `CHK("wr_busy", 1'b1, bus_busy_flag)
    issue(8'h3C, 1'b1);
    issue(`OWBE_CMD_READ_BYTE, 1'b0);
    `CHK("rd_nack", 1'b1, cmd_nack)
    `CHK("apu_on", 1'b1, active_pullup_on)
    issue(`OWBE_CMD_WRITE_BYTE, 1'b0);
    `CHK("wr_nack", 1'b1, cmd_nack)
    // data byte of the refused write; it must not reach a later command
    issue(8'hFF, 1'b1);
    settle;
    `CHK("wr_bits", 8'h3C, rx_byte)
    `CHK("spu_hold", 1'b1, strong_pullup_on)
    @(posedge clock) tx_en <= 1'b1;
    issue(`OWBE_CMD_READ_BYTE, 1'b0);
    `CHK("rd_ack", 1'b1, cmd_ack)
    settle;
    `CHK("rd_data", tx_byte, read_data)
    `CHK("rd_ptr", `OWBE_PTR_STATUS, read_pointer)
    for (i = 0; i < 3; i = i + 1)
    begin
      @(posedge clock) tx_en <= (i == 0);
      od_en <= (i == 1);
      issue(`OWBE_CMD_SINGLE_BIT, 1'b0);
      issue(i == 0 ? 8'hFE : (i == 1 ? 8'h7F : 8'h80), 1'b1);
      // a short slot has ended by now, a standard one has not
      repeat (30) @(posedge clock);
      #1;
      `CHK("slot_len", i != 1, bus_busy_flag)
      settle;
      `CHK("sbr", i == 2, single_bit_result)
      `CHK("slot_val", i == 2, rx_byte[7])
    end
    `CHK("line_out", 1'b0, line_out)
    wrap_up;
  end
endmodule

// *** verification/owbe_slave_model.sv ***
`timescale 1ns/10ps
// ****************************************
// bus slave: samples writes, pulls low for zero reads
// ****************************************
module owbe_slave_model (
  input wire clock,
  input wire line_oe_n,
  input wire tx_en,
  input wire [7:0] tx_byte,
  output wire line_in,
  output reg [7:0] rx_byte
);
  integer t = 99;
  reg [2:0] n = 3'h0;
  reg prev = 1'b1;
  // pull-up wins once both sides let go
  assign line_in = line_oe_n && !(tx_en && !tx_byte[n] && t < 20);
  always @(posedge clock)
  begin
    prev <= line_oe_n;
    // strict compare: the unknown drive before reset must not poison t
    t <= (prev === 1'b1 && line_oe_n === 1'b0) ? 0 : t + 1;
    if (t == 15)
    begin
      rx_byte <= {line_in, rx_byte[7:1]};
      n <= n + 3'h1;
    end
  end
endmodule
